// ### design/wrp_bus_cond.sv
// start, stop and clock edge detection on the two-wire bus
`timescale 1ns/100ps
module wrp_bus_cond (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic start_det,
   output logic stop_det,
   output logic scl_rise,
   output logic scl_fall
);
   import wrp_pkg::*;

   logic scl_q;
   logic sda_q;
   logic next_scl_q;
   logic next_sda_q;

   // ***************************************************
   // line history
   // ***************************************************
   always_comb begin
      next_scl_q = scl_in;
      next_sda_q = sda_in;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= next_scl_q;
         sda_q <= next_sda_q;
      end
   end

   // ***************************************************
   // conditions
   // ***************************************************
   assign start_det = scl_q & scl_in & sda_q & ~sda_in; // R12
   assign stop_det = scl_q & scl_in & ~sda_q & sda_in; // R13
   assign scl_rise = ~scl_q & scl_in;
   assign scl_fall = scl_q & ~scl_in;

   AST_COND_EXCLUSIVE: assert property (@(posedge core_clk) disable iff (sys_rst) // R12
      !(start_det && stop_det) && !(start_det && (scl_rise || scl_fall)))
      else $error("start seen with stop or clock edge");

endmodule // wrp_bus_cond

// ### design/wrp_pkg.sv
// constants and types shared by the wiper power control block
package wrp_pkg;

   // ***************************************************
   // wiper register
   // ***************************************************
   localparam int WIPER_W = 7;
   localparam int TAP_COUNT = 128;
   localparam logic [6:0] WIPER_DEFAULT = 7'h3f;
   localparam logic [6:0] ZERO_SCALE_CODE = 7'h00;
   localparam logic [6:0] FULL_SCALE_CODE = 7'h7f;

   // ***************************************************
   // serial framing
   // ***************************************************
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2e;
   localparam logic [7:0] CMD_WIPER_DEFAULT = 8'h00;
   localparam int BIT_CNT_W = 4;
   localparam logic [3:0] BYTE_DONE = 4'h8;
   localparam logic [3:0] BIT_CNT_RESET = 4'h0;

   // ***************************************************
   // serial state machine
   // ***************************************************
   typedef enum logic [8:0] {
      WRP_IDLE     = 9'h001,
      WRP_ADDR     = 9'h002,
      WRP_ADDR_ACK = 9'h004,
      WRP_CMD      = 9'h008,
      WRP_CMD_ACK  = 9'h010,
      WRP_DATA     = 9'h020,
      WRP_DATA_ACK = 9'h040,
      WRP_RD       = 9'h080,
      WRP_RD_ACK   = 9'h100
   } wrp_state_t;

endpackage

// ### design/wrp_power_ctrl.sv
// wiper register, power state and serial slave of the digital potentiometer
`timescale 1ns/100ps

// What this block does
// (R1) supply rising past trip point loads wiper with 3Fh and enables logic
// (R2) supply below trip point disables serial interface, bus ignored
// (R3) stop condition puts the device into static operation
// (R4) start condition makes the device serial-active
// (R5) code 0x00 selects the zero-scale end tap
// (R6) code 0x7F selects the full-scale end tap
// (R7) device is slave only and never drives the serial clock
// (R8) above trip point valid commands read and write the wiper
// (R9) write cut by brown-out may not finish; wiper may be corrupt
// (R10) between trip point and 1.8V wiper holds default, commands not guaranteed
// (R11) host system should stay in reset below minimum supply; this block only receives sys_rst and does not enforce it
// (R12) start is data falling while clock high
// (R13) stop is data rising while clock high, ending the transfer
// (R14) wiper is 7 bits; selected tap follows it when operational
// (R15) power-on load beats serial access; serial restarts idle
module wrp_power_ctrl #(
   parameter logic [6:0] DEV_ADDR = wrp_pkg::DEV_ADDR_DEFAULT,
   parameter logic [7:0] CMD_WIPER = wrp_pkg::CMD_WIPER_DEFAULT
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic supply_ok,
   input wire logic supply_in_range,
   input wire logic above_retention_level,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic scl_oe,
   output logic sda_out,
   output logic sda_oe,
   output logic [wrp_pkg::WIPER_W-1:0] wiper_code,
   output logic wiper_valid,
   output logic [wrp_pkg::TAP_COUNT-1:0] tap_sel,
   output logic zero_scale_sel,
   output logic full_scale_sel,
   output logic serial_active
);
   import wrp_pkg::*;

   wrp_state_t state;
   wrp_state_t next_state;
   logic [BIT_CNT_W-1:0] bit_cnt;
   logic [BIT_CNT_W-1:0] next_bit_cnt;
   logic [7:0] shreg;
   logic [7:0] next_shreg;
   logic [WIPER_W-1:0] next_wiper_code;
   logic next_sda_oe;
   logic next_serial_active;
   logic next_wiper_valid;
   logic supply_prev;
   logic next_supply_prev;
   logic start_det;
   logic stop_det;
   logic scl_rise;
   logic scl_fall;
   logic byte_in;
   logic bus_live;

   // ***************************************************
   // bus conditions and tap decode
   // ***************************************************
   wrp_bus_cond u_cond (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .start_det(start_det),
      .stop_det(stop_det),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall)
   );

   wrp_tap_decode #(
      .CODE_W(WIPER_W),
      .TAPS(TAP_COUNT)
   ) u_tap (
      .wiper_code(wiper_code),
      .tap_sel(tap_sel),
      .zero_scale_sel(zero_scale_sel),
      .full_scale_sel(full_scale_sel)
   );

   // ***************************************************
   // open-drain pins
   // ***************************************************
   assign scl_out = 1'b0;
   assign scl_oe = 1'b0; // R7
   assign sda_out = 1'b0;
   assign byte_in = scl_fall && (bit_cnt == BYTE_DONE);

   // ***************************************************
   // power state and serial slave, next values
   // ***************************************************
   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_wiper_code = wiper_code;
      next_sda_oe = sda_oe;
      next_serial_active = serial_active;
      next_wiper_valid = wiper_valid;
      next_supply_prev = supply_ok;
      if (!above_retention_level) begin
         next_wiper_valid = 1'b0; // R9
      end
      if (!supply_ok) begin
         next_state = WRP_IDLE; // R2
         next_sda_oe = 1'b0;
         next_serial_active = 1'b0;
         next_bit_cnt = BIT_CNT_RESET;
      end else if (!supply_prev || !supply_in_range) begin
         next_wiper_code = WIPER_DEFAULT; // R1 R10
         next_wiper_valid = 1'b1;
         next_state = WRP_IDLE; // R15
         next_sda_oe = 1'b0;
         next_serial_active = 1'b0;
         next_bit_cnt = BIT_CNT_RESET;
      end else if (stop_det) begin
         next_serial_active = 1'b0; // R3
         next_state = WRP_IDLE; // R13
         next_sda_oe = 1'b0;
      end else if (start_det) begin
         next_serial_active = 1'b1; // R4
         next_state = WRP_ADDR; // R12
         next_sda_oe = 1'b0;
         next_bit_cnt = BIT_CNT_RESET;
      end else begin
         case (state)
            WRP_IDLE: begin
               next_sda_oe = 1'b0;
            end
            WRP_ADDR, WRP_CMD, WRP_DATA: begin
               if (scl_rise) begin
                  next_shreg = {shreg[6:0], sda_in};
                  next_bit_cnt = bit_cnt + 4'h1;
               end else if (byte_in) begin
                  next_bit_cnt = BIT_CNT_RESET;
                  next_sda_oe = 1'b1;
                  if (state == WRP_ADDR) begin
                     if (shreg[7:1] == DEV_ADDR) begin
                        next_state = WRP_ADDR_ACK;
                     end else begin
                        next_state = WRP_IDLE;
                        next_sda_oe = 1'b0;
                     end
                  end else if (state == WRP_CMD) begin
                     if (shreg == CMD_WIPER) begin
                        next_state = WRP_CMD_ACK;
                     end else begin
                        next_state = WRP_IDLE;
                        next_sda_oe = 1'b0;
                     end
                  end else begin
                     next_wiper_code = shreg[WIPER_W-1:0]; // R8 R9
                     next_state = WRP_DATA_ACK;
                  end
               end
            end
            WRP_ADDR_ACK: begin
               if (scl_fall) begin
                  next_bit_cnt = BIT_CNT_RESET;
                  if (shreg[0]) begin
                     next_shreg = {1'b0, wiper_code}; // R8
                     next_sda_oe = 1'b1;
                     next_state = WRP_RD;
                  end else begin
                     next_sda_oe = 1'b0;
                     next_state = WRP_CMD;
                  end
               end
            end
            WRP_CMD_ACK, WRP_DATA_ACK: begin
               if (scl_fall) begin
                  next_sda_oe = 1'b0;
                  next_bit_cnt = BIT_CNT_RESET;
                  next_state = WRP_DATA;
               end
            end
            WRP_RD: begin
               if (scl_rise) begin
                  next_bit_cnt = bit_cnt + 4'h1;
               end else if (byte_in) begin
                  next_sda_oe = 1'b0;
                  next_state = WRP_RD_ACK;
               end else if (scl_fall) begin
                  next_shreg = {shreg[6:0], 1'b0};
                  next_sda_oe = ~shreg[6];
               end
            end
            WRP_RD_ACK: begin
               if (scl_rise) begin
                  next_shreg = {7'h00, sda_in};
               end else if (scl_fall) begin
                  next_bit_cnt = BIT_CNT_RESET;
                  if (shreg[0]) begin
                     next_state = WRP_IDLE;
                     next_sda_oe = 1'b0;
                  end else begin
                     next_shreg = {1'b0, wiper_code};
                     next_sda_oe = 1'b1;
                     next_state = WRP_RD;
                  end
               end
            end
            default: begin
               next_state = WRP_IDLE;
               next_sda_oe = 1'b0;
            end
         endcase
      end
   end

   // ***************************************************
   // registers
   // ***************************************************
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state <= WRP_IDLE;
         bit_cnt <= BIT_CNT_RESET;
         shreg <= 8'h00;
         wiper_code <= WIPER_DEFAULT;
         sda_oe <= 1'b0;
         serial_active <= 1'b0;
         wiper_valid <= 1'b0;
         supply_prev <= 1'b0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         wiper_code <= next_wiper_code;
         sda_oe <= next_sda_oe;
         serial_active <= next_serial_active;
         wiper_valid <= next_wiper_valid;
         supply_prev <= next_supply_prev;
      end
   end

   // ***************************************************
   // checks
   // ***************************************************
   assign bus_live = supply_ok && supply_prev && supply_in_range && !stop_det && !start_det;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   AST_POR_LOAD: assert property ($rose(supply_ok) |=> wiper_code == WIPER_DEFAULT && wiper_valid) // R1
      else $error("default not loaded on supply rise");
   AST_BROWNOUT_QUIET: assert property (!supply_ok |=> !sda_oe && state == WRP_IDLE && !serial_active) // R2
      else $error("serial port alive below trip point");
   AST_STOP_STATIC: assert property (supply_ok && supply_prev && supply_in_range && stop_det // R3
      |=> !serial_active && state == WRP_IDLE)
      else $error("stop did not enter static operation");
   AST_START_ACTIVE: assert property (supply_ok && supply_prev && supply_in_range && start_det // R4
      |=> serial_active && state == WRP_ADDR && bit_cnt == BIT_CNT_RESET)
      else $error("start did not make the port active");
   AST_ZERO_TAP: assert property (wiper_code == ZERO_SCALE_CODE |-> zero_scale_sel && !full_scale_sel) // R5
      else $error("zero-scale tap not selected");
   AST_FULL_TAP: assert property (wiper_code == FULL_SCALE_CODE |-> full_scale_sel && !zero_scale_sel) // R6
      else $error("full-scale tap not selected");
   AST_NO_CLOCK_DRIVE: assert property (!scl_oe) // R7
      else $error("serial clock driven by slave");
   AST_WRITE_COMMIT: assert property (supply_ok && supply_prev && supply_in_range && !stop_det && !start_det // R8
      && state == WRP_DATA && byte_in |=> wiper_code == $past(shreg[6:0]) && sda_oe)
      else $error("data byte not written to wiper");
   AST_RETENTION_LOSS: assert property (!above_retention_level |=> !wiper_valid) // R9
      else $error("wiper marked valid below retention level");
   AST_LOW_RANGE_HOLD: assert property (supply_ok && !supply_in_range |=> wiper_code == WIPER_DEFAULT // R10
      && !sda_oe)
      else $error("wiper not held at default in low range");
   AST_TAP_FOLLOWS: assert property ($onehot(tap_sel) && tap_sel[wiper_code]) // R14
      else $error("tap select does not follow wiper");
   AST_POR_IDLE: assert property (supply_ok && !supply_prev // R15
      |=> state == WRP_IDLE && !serial_active && !sda_oe)
      else $error("serial access survived power-on load");
   AST_ADDR_ACK: assert property (bus_live && state == WRP_ADDR && byte_in && shreg[7:1] == DEV_ADDR // R8
      |=> state == WRP_ADDR_ACK && sda_oe)
      else $error("matching address not acknowledged");
   AST_ADDR_REFUSE: assert property (bus_live && state == WRP_ADDR && byte_in && shreg[7:1] != DEV_ADDR // R8
      |=> state == WRP_IDLE && !sda_oe)
      else $error("foreign address acknowledged");
   AST_CMD_REFUSE: assert property (bus_live && state == WRP_CMD && byte_in && shreg != CMD_WIPER // R8
      |=> state == WRP_IDLE && !sda_oe)
      else $error("unknown command acknowledged");
   AST_ACK_RELEASE: assert property (bus_live && (state == WRP_CMD_ACK || state == WRP_DATA_ACK) && scl_fall // R8
      |=> state == WRP_DATA && !sda_oe)
      else $error("acknowledge not released");
   AST_READ_BIT: assert property (bus_live && state == WRP_RD && scl_fall && bit_cnt != BYTE_DONE // R8
      |=> sda_oe == !$past(shreg[6]))
      else $error("read bit not presented");
   AST_RD_NAK: assert property (bus_live && state == WRP_RD_ACK && scl_fall && shreg[0] // R8
      |=> state == WRP_IDLE && !sda_oe)
      else $error("read not ended on master nak");
   AST_RD_RELOAD: assert property (bus_live && state == WRP_RD_ACK && scl_fall && !shreg[0] // R8
      |=> state == WRP_RD && sda_oe && !shreg[7])
      else $error("read not repeated on master ack");

   COV_WRITE: cover property (state == WRP_DATA ##1 state == WRP_DATA_ACK);
   COV_READ: cover property (state == WRP_RD_ACK ##1 state == WRP_RD);
   COV_BROWNOUT: cover property (serial_active ##1 !supply_ok);
   COV_STATIC: cover property (serial_active ##1 !serial_active);
   COV_REFUSED: cover property (state == WRP_ADDR ##1 state == WRP_IDLE && serial_active);

endmodule // wrp_power_ctrl

// ### design/wrp_tap_decode.sv
// wiper code to one-hot tap select of the resistor string
`timescale 1ns/100ps
module wrp_tap_decode #(
   parameter int CODE_W = wrp_pkg::WIPER_W,
   parameter int TAPS = wrp_pkg::TAP_COUNT
) (
   input wire logic [CODE_W-1:0] wiper_code,
   output logic [TAPS-1:0] tap_sel,
   output logic zero_scale_sel,
   output logic full_scale_sel
);
   import wrp_pkg::*;

   // ***************************************************
   // one tap per code
   // ***************************************************
   for (genvar i = 0; i < TAPS; i++) begin : g_tap
      assign tap_sel[i] = (wiper_code == CODE_W'(i)); // R14
   end

   assign zero_scale_sel = tap_sel[0]; // R5
   assign full_scale_sel = tap_sel[TAPS-1]; // R6

endmodule // wrp_tap_decode

// ### verification/test_wrp_power_ctrl.sv
// self-checking bench for the wiper power control block
`timescale 1ns/100ps
module test_wrp_power_ctrl;
   import wrp_pkg::*;
   // ***************************************************
   // signals and instances
   // ***************************************************
   localparam logic [7:0] WR_ADDR = {DEV_ADDR_DEFAULT, 1'b0};
   localparam logic [7:0] RD_ADDR = {DEV_ADDR_DEFAULT, 1'b1};
   logic core_clk;
   logic sys_rst;
   logic supply_ok;
   logic supply_in_range;
   logic above_retention_level;
   logic scl_low;
   logic sda_low;
   logic scl_out;
   logic scl_oe;
   logic sda_out;
   logic sda_oe;
   logic [WIPER_W-1:0] wiper_code;
   logic wiper_valid;
   logic [TAP_COUNT-1:0] tap_sel;
   logic zero_scale_sel;
   logic full_scale_sel;
   logic serial_active;
   logic scl_line;
   logic sda_line;
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;
   // pulled-up open-drain lines
   assign scl_line = ~(scl_low | (scl_oe & ~scl_out));
   assign sda_line = ~(sda_low | (sda_oe & ~sda_out));
   wrp_power_ctrl wrp_power_ctrl_inst (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .supply_ok(supply_ok),
      .supply_in_range(supply_in_range),
      .above_retention_level(above_retention_level),
      .scl_in(scl_line),
      .sda_in(sda_line),
      .scl_out(scl_out),
      .scl_oe(scl_oe),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .wiper_code(wiper_code),
      .wiper_valid(wiper_valid),
      .tap_sel(tap_sel),
      .zero_scale_sel(zero_scale_sel),
      .full_scale_sel(full_scale_sel),
      .serial_active(serial_active)
   );
   wrp_master_model wrp_master_model_inst (
      .core_clk(core_clk),
      .sda_line(sda_line),
      .scl_low(scl_low),
      .sda_low(sda_low)
   );
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         summarize();
      end
   end
   // ***************************************************
   // helpers
   // ***************************************************
   task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic clk(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic xfer(input logic [7:0] b, input logic exp_nak);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         wrp_master_model_inst.bit_io(~b[i], s);
      end
      wrp_master_model_inst.bit_io(1'b0, s);
      chk("ack bit", exp_nak, s);
   endtask
   task automatic rd_byte(input logic ack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         wrp_master_model_inst.bit_io(1'b0, s);
         b[i] = s;
      end
      wrp_master_model_inst.bit_io(ack, s);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d, input logic [2:0] naks);
      wrp_master_model_inst.start_cond();
      xfer(a, naks[2]);
      xfer(c, naks[1]);
      xfer(d, naks[0]);
      wrp_master_model_inst.stop_cond();
   endtask
   // ***************************************************
   // scenarios
   // ***************************************************
   task automatic test_power_up();
      chk("valid before load", 1'b0, wiper_valid);
      supply_in_range = 1'b1;
      above_retention_level = 1'b1;
      supply_ok = 1'b1;
      clk(1);
      chk("wiper after load", WIPER_DEFAULT, wiper_code);
      chk("valid after load", 1'b1, wiper_valid);
      chk("mid tap", 128'h1 << 63, tap_sel);
      chk("clock drive", 1'b0, scl_oe);
      chk("clock pin", 1'b0, scl_out);
      chk("data pin", 1'b0, sda_out);
      $display("test power_up done");
   endtask
   task automatic test_write();
      wrp_master_model_inst.start_cond();
      chk("active after start", 1'b1, serial_active);
      xfer(WR_ADDR, 1'b0);
      xfer(CMD_WIPER_DEFAULT, 1'b0);
      xfer(8'h00, 1'b0);
      chk("zero code", ZERO_SCALE_CODE, wiper_code);
      chk("zero end", 1'b1, zero_scale_sel);
      chk("zero tap", 128'h1, tap_sel);
      wrp_master_model_inst.h = 6;
      xfer(8'hff, 1'b0);
      chk("full code", FULL_SCALE_CODE, wiper_code);
      chk("full end", 1'b1, full_scale_sel);
      chk("full tap", 128'h1 << 127, tap_sel);
      wrp_master_model_inst.stop_cond();
      wrp_master_model_inst.h = 3;
      chk("static after stop", 1'b0, serial_active);
      $display("test write done");
   endtask
   task automatic test_read();
      logic [7:0] b;
      wrp_master_model_inst.start_cond();
      xfer(RD_ADDR, 1'b0);
      rd_byte(1'b1, b);
      chk("read byte", {1'b0, FULL_SCALE_CODE}, b);
      rd_byte(1'b0, b);
      chk("read again", {1'b0, FULL_SCALE_CODE}, b);
      wrp_master_model_inst.stop_cond();
      chk("data released", 1'b0, sda_oe);
      $display("test read done");
   endtask
   task automatic test_refused();
      wr({DEV_ADDR_DEFAULT ^ 7'h01, 1'b0}, CMD_WIPER_DEFAULT, 8'h11, 3'b111);
      wr(WR_ADDR, CMD_WIPER_DEFAULT ^ 8'h01, 8'h11, 3'b011);
      chk("wiper kept", FULL_SCALE_CODE, wiper_code);
      $display("test refused done");
   endtask
   task automatic test_low_range();
      wr(WR_ADDR, CMD_WIPER_DEFAULT, 8'h11, 3'b000);
      chk("wiper written", 7'h11, wiper_code);
      supply_in_range = 1'b0;
      clk(1);
      chk("default held", WIPER_DEFAULT, wiper_code);
      wr(WR_ADDR, CMD_WIPER_DEFAULT, 8'h22, 3'b111);
      chk("still default", WIPER_DEFAULT, wiper_code);
      supply_in_range = 1'b1;
      clk(1);
      $display("test low_range done");
   endtask
   task automatic test_brown_out();
      wr(WR_ADDR, CMD_WIPER_DEFAULT, 8'h7f, 3'b000);
      wrp_master_model_inst.start_cond();
      xfer(WR_ADDR, 1'b0);
      supply_ok = 1'b0;
      clk(2);
      chk("inactive below trip", 1'b0, serial_active);
      chk("sda below trip", 1'b0, sda_oe);
      above_retention_level = 1'b0;
      clk(2);
      chk("valid lost", 1'b0, wiper_valid);
      xfer(CMD_WIPER_DEFAULT, 1'b1);
      xfer(8'h11, 1'b1);
      wrp_master_model_inst.stop_cond();
      above_retention_level = 1'b1;
      supply_ok = 1'b1;
      clk(1);
      chk("reload", WIPER_DEFAULT, wiper_code);
      chk("valid again", 1'b1, wiper_valid);
      chk("idle after reload", 1'b0, serial_active);
      chk("sda after reload", 1'b0, sda_oe);
      wr(WR_ADDR, CMD_WIPER_DEFAULT, 8'h22, 3'b000);
      chk("write after reload", 7'h22, wiper_code);
      $display("test brown_out done");
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      sys_rst = 1'b1;
      supply_ok = 1'b0;
      supply_in_range = 1'b0;
      above_retention_level = 1'b0;
      clk(8);
      sys_rst = 1'b0;
      clk(2);
      test_power_up();
      test_write();
      test_read();
      test_refused();
      test_low_range();
      test_brown_out();
      summarize();
   end
endmodule // test_wrp_power_ctrl

// ### verification/wrp_master_model.sv
// two-wire bus master model that owns the serial clock
`timescale 1ns/100ps
module wrp_master_model (
   input wire logic core_clk,
   input wire logic sda_line,
   output logic scl_low,
   output logic sda_low
);
   // ***************************************************
   // bus cycles, bit cycles enter and exit with clock low; start exits and stop enters with clock low
   // ***************************************************
   int h = 3;
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic bit_io(input logic drive_low, output logic seen);
      tick(h);
      sda_low = drive_low;
      tick(h);
      scl_low = 1'b0;
      tick(h);
      seen = sda_line;
      tick(h);
      scl_low = 1'b1;
   endtask
   task automatic start_cond();
      tick(h);
      sda_low = 1'b0;
      tick(h);
      scl_low = 1'b0;
      tick(h);
      sda_low = 1'b1;
      tick(h);
      scl_low = 1'b1;
   endtask
   task automatic stop_cond();
      tick(h);
      sda_low = 1'b1;
      tick(h);
      scl_low = 1'b0;
      tick(h);
      sda_low = 1'b0;
      tick(h);
   endtask
endmodule // wrp_master_model
